/* tb/host_uart_model.sv */
`timescale 1ns/1ps
module host_uart_model #(
    parameter int BIT_CYC = 10
)(
    input  wire logic  clk,
    input  wire logic  txd,
    input  wire logic  busy,
    output logic       rxd,
    output logic       rts_n,
    output logic [7:0] got_byte,
    output logic       got_ok,
    output logic       got_stb
);
    initial
    begin
        rxd      = 1'b1;
        rts_n    = 1'b1;
        got_byte = 8'h00;
        got_ok   = 1'b0;
        got_stb  = 1'b0;
    end
    // decode each character the device sends, sampling mid bit
    always
    begin : rx_proc
        logic [7:0] sh;
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYC) @(posedge clk);
            sh[i] = txd;
        end
        repeat (BIT_CYC) @(posedge clk);
        got_byte <= sh;
        got_ok   <= txd;
        got_stb  <= 1'b1;
        @(posedge clk);
        got_stb  <= 1'b0;
    end
    task automatic send_char(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            rxd <= fr[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
    endtask : send_char
    task automatic set_rts(input logic v);
        @(posedge clk);
        rts_n <= v;
    endtask : set_rts
    // sample busy before a command; interrupt and wait if it is high
    task automatic wait_ready();
        int n;
        if (busy === 1'b1)
        begin
            set_rts(1'b0);
            n = 0;
            while (busy !== 1'b0 && n < 50)
            begin
                @(posedge clk);
                n++;
            end
            set_rts(1'b1);
        end
    endtask : wait_ready
endmodule : host_uart_model

/* tb/tb_serial_host_port.sv */
`timescale 1ns/1ps
module tb_serial_host_port;
    import host_port_pkg::*;
    localparam int BIT_CYC = 10;
    logic       clk, rst, ce, msg_valid, is_sp, is_lf, accepted, mon_all, filt;
    logic       sp_on, lf_on, opt_wr, processing, op_restart;
    logic [7:0] msg_data, opt_byte;
    logic       rxd, rts_n, txd, busy, intr, abandon, pwr_en, msg_ready, rx_valid;
    logic [7:0] rx_data, got_byte;
    logic       got_ok, got_stb, rx_seen_ff;
    logic [9:0] buf_level;
    logic [7:0] exp_tx[$];
    logic [7:0] exp_rx[$];
    int         miscompares, cmp_count, int_cnt, busy_hi;
    string      ovf;

    serial_host_port #(.BAUD(2500000)) u_dut (
        .CLK_SYS(clk), .RST(rst), .CE(ce), .MSG_DATA(msg_data), .MSG_VALID(msg_valid),
        .MSG_READY(msg_ready), .MSG_IS_SPACE(is_sp), .MSG_IS_LF(is_lf), .MSG_ACCEPTED(accepted),
        .MONITOR_ALL(mon_all), .FILTERS_SET(filt), .SPACES_ON(sp_on), .LINEFEEDS_ON(lf_on),
        .OPTION_BYTE(opt_byte), .OPTION_WR(opt_wr), .PROCESSING(processing),
        .OP_RESTART(op_restart), .RXD(rxd), .RTS_N(rts_n), .TXD(txd), .BUSY(busy),
        .INTERRUPT(intr), .ABANDON(abandon), .PWR_CTRL_EN(pwr_en), .RX_DATA(rx_data),
        .RX_VALID(rx_valid), .BUF_LEVEL(buf_level));
    host_uart_model #(.BIT_CYC(BIT_CYC)) u_host (
        .clk(clk), .txd(txd), .busy(busy), .rxd(rxd), .rts_n(rts_n),
        .got_byte(got_byte), .got_ok(got_ok), .got_stb(got_stb));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic fail(input string m);
        $display("[FAIL] %0t %s", $time, m);
        miscompares++;
    endtask : fail
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e, input string m);
        cmp_count++;
        if (g !== e)
            fail($sformatf("%s got %h exp %h", m, g, e));
    endtask : cmp_byte
    task automatic cmp_bit(input logic g, input logic e, input string m);
        cmp_count++;
        if (g !== e)
            fail(m);
    endtask : cmp_bit
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic push_msg(input logic [7:0] d, input logic s, input logic l);
        @(posedge clk);
        msg_valid <= 1'b1;
        msg_data  <= d;
        is_sp     <= s;
        is_lf     <= l;
        accepted  <= 1'($urandom);
        @(posedge clk);
        msg_valid <= 1'b0;
    endtask : push_msg
    task automatic host_send(input logic [7:0] b);
        exp_rx.push_back(b);
        u_host.send_char(b);
        repeat (4) @(posedge clk);
    endtask : host_send
    // note every character the buffer takes in
    always @(posedge clk)
        if (!rst && ce && msg_valid && msg_ready && (accepted || (mon_all && !filt))
            && !(is_sp && !sp_on) && !(is_lf && !lf_on))
            exp_tx.push_back(msg_data);
    always @(posedge clk)
    begin
        if (got_stb === 1'b1)
        begin
            cmp_bit(got_ok, 1'b1, "stop bit");
            if (exp_tx.size() == 0)
                fail("unexpected tx char");
            else
                cmp_byte(got_byte, exp_tx.pop_front(), "tx char");
        end
        if (rx_seen_ff)
            cmp_bit(intr, 1'b1, "no interrupt after host char");
        rx_seen_ff <= (rx_valid === 1'b1);
        if (rx_valid === 1'b1)
        begin
            if (exp_rx.size() == 0)
                fail("unexpected rx char");
            else
                cmp_byte(rx_data, exp_rx.pop_front(), "rx char");
        end
        if (intr === 1'b1)
        begin
            int_cnt++;
            processing <= 1'b0;
        end
        if (busy === 1'b1)
            busy_hi++;
    end
    initial
    begin : watchdog
        repeat (90000) @(posedge clk);
        fail("timeout");
        close_out();
    end
    initial
    begin : main
        int n, ic;
        {ce, rst, mon_all, sp_on, lf_on} = 5'b11111;
        {msg_valid, is_sp, is_lf, accepted, filt, opt_wr, processing, op_restart} = 8'h00;
        {rx_seen_ff, miscompares, cmp_count, int_cnt, busy_hi} = '0;
        msg_data = 8'h00;
        opt_byte = 8'h00;
        ovf = "BUFFER FULL";
        void'($urandom(90));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        cmp_bit(txd, 1'b1, "txd idle");
        cmp_bit(busy, 1'b0, "busy at reset");
        cmp_bit(pwr_en, 1'b1, "power control at reset");
        cmp_bit(msg_ready, 1'b1, "ready at reset");
        cmp_bit(buf_level === 10'h000, 1'b1, "level at reset");
        for (int i = 0; i < 16; i++)
        begin
            sp_on <= (i < 8);
            lf_on <= (i < 8);
            filt  <= (i >= 12);
            push_msg(8'($urandom), (i % 3) == 1, (i % 3) == 2);
        end
        filt <= 1'b0;
        host_send(8'($urandom));
        processing <= 1'b1;
        ic = int_cnt;
        u_host.set_rts(1'b0);
        repeat (6) @(posedge clk);
        cmp_bit(busy, 1'b0, "busy with handshake off");
        cmp_bit(int_cnt == ic, 1'b1, "rts acted with handshake off");
        u_host.set_rts(1'b1);
        @(posedge clk);
        opt_byte <= 8'h3f;
        opt_wr   <= 1'b1;
        @(posedge clk);
        opt_wr   <= 1'b0;
        processing <= 1'b1;
        repeat (4) @(posedge clk);
        cmp_bit(pwr_en, 1'b0, "power control not off");
        cmp_bit(busy, 1'b1, "busy not high while processing");
        ic = int_cnt;
        u_host.wait_ready();
        cmp_bit(int_cnt > ic, 1'b1, "rts low gave no interrupt");
        cmp_bit(busy, 1'b0, "busy not low after interrupt");
        busy_hi = 0;
        repeat (20) @(posedge clk);
        cmp_bit(busy_hi == 0, 1'b1, "busy came back after rts rose");
        host_send(8'($urandom));
        n = 0;
        while (abandon !== 1'b1 && n < 900)
        begin
            @(posedge clk);
            msg_valid <= 1'b1;
            msg_data  <= 8'($urandom);
            n++;
        end
        cmp_bit(abandon, 1'b1, "no overflow");
        cmp_bit(buf_level >= 10'd511, 1'b1, "buffer not 512 deep");
        for (int i = 0; i < 11; i++)
            exp_tx.push_back(ovf[i]);
        @(posedge clk);
        msg_valid <= 1'b0;
        #1;
        cmp_bit(abandon, 1'b0, "abandon not a pulse");
        cmp_bit(msg_ready, 1'b0, "ready during halt");
        n = 0;
        while ((exp_tx.size() != 0 || txd !== 1'b1) && n < 80000)
        begin
            @(posedge clk);
            n++;
        end
        repeat (2 * BIT_CYC) @(posedge clk);
        cmp_bit(exp_tx.size() == 0, 1'b1, "tx not drained");
        cmp_bit(txd, 1'b1, "txd not idle");
        op_restart <= 1'b1;
        @(posedge clk);
        op_restart <= 1'b0;
        repeat (2) @(posedge clk);
        cmp_bit(msg_ready, 1'b1, "ready after restart");
        ce <= 1'b0;
        push_msg(8'h41, 1'b0, 1'b0);
        repeat (2) @(posedge clk);
        cmp_bit(buf_level === 10'h000, 1'b1, "ce low did not freeze buffer");
        close_out();
    end
endmodule : tb_serial_host_port

/* verilog/byte_stream_if.sv */
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

/* verilog/host_port_consts.svh */
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
`define CLK_HZ            25000000
`define BAUD_DEFAULT      115200
`define BUF_BYTES         512
`define FIFO_WORDS        4
`define OPT_BYTE_RESET    8'hff
`define OPT_HS_EN_BIT     6
`define OPT_PWR_BIT       7
`define OVF_LEN           4'd11
`endif

/* verilog/host_port_pkg.sv */
package host_port_pkg;
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b10,
        TX_STOP  = 2'b11
    } ser_state_t;
    typedef enum logic [1:0] {
        SRC_MSG  = 2'b00,
        SRC_OVF  = 2'b01,
        SRC_HALT = 2'b10
    } src_state_t;
endpackage : host_port_pkg

/* verilog/serial_host_port.sv */
`timescale 1ns/1ps
`include "host_port_consts.svh"
module serial_host_port
    import host_port_pkg::*;
#(
    parameter int BAUD      = `BAUD_DEFAULT,
    parameter int BUF_BYTES = `BUF_BYTES,
    parameter int FIFO_W    = `FIFO_WORDS
)(
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    input  wire logic       CE,
    input  wire logic [7:0] MSG_DATA,
    input  wire logic       MSG_VALID,
    output logic            MSG_READY,
    input  wire logic       MSG_IS_SPACE,
    input  wire logic       MSG_IS_LF,
    input  wire logic       MSG_ACCEPTED,
    input  wire logic       MONITOR_ALL,
    input  wire logic       FILTERS_SET,
    input  wire logic       SPACES_ON,
    input  wire logic       LINEFEEDS_ON,
    input  wire logic [7:0] OPTION_BYTE,
    input  wire logic       OPTION_WR,
    input  wire logic       PROCESSING,
    input  wire logic       OP_RESTART,
    input  wire logic       RXD,
    input  wire logic       RTS_N,
    output logic            TXD,
    output logic            BUSY,
    output logic            INTERRUPT,
    output logic            ABANDON,
    output logic            PWR_CTRL_EN,
    output logic [7:0]      RX_DATA,
    output logic            RX_VALID,
    output logic [9:0]      BUF_LEVEL
);
    localparam int BIT_CYC = (`CLK_HZ / BAUD) < 1 ? 1 : (`CLK_HZ / BAUD);
    localparam int LW = $clog2(BUF_BYTES + 1);

    byte_stream_if #(.W(8)) to_fifo ();
    byte_stream_if #(.W(8)) from_fifo ();

    logic [7:0]      opt_ff;
    src_state_t      src_ff;
    logic [3:0]      ovf_idx_ff;
    logic [LW-1:0]   level_ff;
    logic [8:0]      bwp_ff;
    logic [8:0]      brp_ff;
    logic [7:0]      bmem [BUF_BYTES];
    logic            abandon_ff;
    logic            msg_keep;
    logic            drop_char;
    logic            buf_push;
    logic            buf_pop;
    logic            buf_full;
    logic            buf_empty;
    logic [7:0]      ovf_char;
    logic            hs_en;
    logic            busy_ff;
    logic            intr_ff;
    logic            rts_d_ff;
    ser_state_t      tx_st_ff;
    logic [15:0]     tx_cnt_ff;
    logic [2:0]      tx_bit_ff;
    logic [7:0]      tx_sh_ff;
    logic            txd_ff;
    ser_state_t      rx_st_ff;
    logic [15:0]     rx_cnt_ff;
    logic [2:0]      rx_bit_ff;
    logic [7:0]      rx_sh_ff;
    logic [7:0]      rx_data_ff;
    logic            rx_valid_ff;
    logic            rx_prev_ff;

    // option byte: default leaves handshake off
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            opt_ff <= `OPT_BYTE_RESET;
        else if (CE && OPTION_WR)
            opt_ff <= OPTION_BYTE;
    end
    assign hs_en       = ~opt_ff[`OPT_HS_EN_BIT] && ~opt_ff[`OPT_PWR_BIT];
    assign PWR_CTRL_EN = opt_ff[`OPT_PWR_BIT];

    // message filtering ahead of the buffer
    assign msg_keep  = MSG_ACCEPTED || (MONITOR_ALL && !FILTERS_SET);
    assign drop_char = (MSG_IS_SPACE && !SPACES_ON) || (MSG_IS_LF && !LINEFEEDS_ON);

    always_comb
    begin
        case (ovf_idx_ff)
            4'd0:    ovf_char = 8'h42;
            4'd1:    ovf_char = 8'h55;
            4'd2:    ovf_char = 8'h46;
            4'd3:    ovf_char = 8'h46;
            4'd4:    ovf_char = 8'h45;
            4'd5:    ovf_char = 8'h52;
            4'd6:    ovf_char = 8'h20;
            4'd7:    ovf_char = 8'h46;
            4'd8:    ovf_char = 8'h55;
            4'd9:    ovf_char = 8'h4c;
            default: ovf_char = 8'h4c;
        endcase
    end

    assign buf_full  = (level_ff == LW'(BUF_BYTES));
    assign buf_empty = (level_ff == '0);
    assign buf_push  = CE && (src_ff == SRC_MSG) && MSG_VALID && msg_keep && !drop_char && !buf_full;
    assign MSG_READY = (src_ff == SRC_MSG) && !buf_full;
    assign to_fifo.valid = !buf_empty || (src_ff == SRC_OVF);
    // report goes out behind the text already buffered
    assign to_fifo.data  = (src_ff == SRC_OVF && buf_empty) ? ovf_char : bmem[brp_ff];
    assign buf_pop = CE && !buf_empty && to_fifo.ready;

    always_ff @(posedge CLK_SYS)
    begin
        if (buf_push)
            bmem[bwp_ff] <= MSG_DATA;
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            bwp_ff   <= '0;
            brp_ff   <= '0;
            level_ff <= '0;
        end
        else
        begin
            if (buf_push)
                bwp_ff <= bwp_ff + 9'h001;
            if (buf_pop)
                brp_ff <= brp_ff + 9'h001;
            level_ff <= level_ff + LW'(buf_push) - LW'(buf_pop);
        end
    end

    // overflow: report, then drop input until restart
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            src_ff     <= SRC_MSG;
            ovf_idx_ff <= 4'h0;
            abandon_ff <= 1'b0;
        end
        else if (CE)
        begin
            abandon_ff <= 1'b0;
            case (src_ff)
                SRC_MSG:
                begin
                    if (buf_full && MSG_VALID && msg_keep && !drop_char)
                    begin
                        src_ff     <= SRC_OVF;
                        ovf_idx_ff <= 4'h0;
                        abandon_ff <= 1'b1;
                    end
                end
                SRC_OVF:
                begin
                    if (to_fifo.ready && buf_empty)
                    begin
                        if (ovf_idx_ff == `OVF_LEN - 4'd1)
                            src_ff <= SRC_HALT;
                        ovf_idx_ff <= ovf_idx_ff + 4'h1;
                    end
                end
                SRC_HALT:
                begin
                    if (OP_RESTART)
                        src_ff <= SRC_MSG;
                end
                default: src_ff <= SRC_MSG;
            endcase
        end
    end
    assign ABANDON = abandon_ff;

    stream_fifo #(.W(8), .D(FIFO_W)) u_fifo (
        .clk   (CLK_SYS),
        .rst   (RST),
        .ce    (CE),
        .in_s  (to_fifo),
        .out_s (from_fifo)
    );

    // transmitter, 8N1 lsb first
    assign from_fifo.ready = CE && (tx_st_ff == TX_IDLE);
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            tx_st_ff  <= TX_IDLE;
            tx_cnt_ff <= '0;
            tx_bit_ff <= '0;
            tx_sh_ff  <= '0;
            txd_ff    <= 1'b1;
        end
        else if (CE)
        begin
            case (tx_st_ff)
                TX_IDLE:
                begin
                    txd_ff <= 1'b1;
                    if (from_fifo.valid)
                    begin
                        tx_sh_ff  <= from_fifo.data;
                        tx_cnt_ff <= 16'(BIT_CYC - 1);
                        txd_ff    <= 1'b0;
                        tx_st_ff  <= TX_START;
                    end
                end
                TX_START, TX_DATA, TX_STOP:
                begin
                    if (tx_cnt_ff != '0)
                        tx_cnt_ff <= tx_cnt_ff - 16'h0001;
                    else
                    begin
                        tx_cnt_ff <= 16'(BIT_CYC - 1);
                        if (tx_st_ff == TX_START)
                        begin
                            txd_ff    <= tx_sh_ff[0];
                            tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
                            tx_bit_ff <= '0;
                            tx_st_ff  <= TX_DATA;
                        end
                        else if (tx_st_ff == TX_DATA)
                        begin
                            if (tx_bit_ff == 3'h7)
                            begin
                                txd_ff   <= 1'b1;
                                tx_st_ff <= TX_STOP;
                            end
                            else
                            begin
                                txd_ff    <= tx_sh_ff[0];
                                tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
                                tx_bit_ff <= tx_bit_ff + 3'h1;
                            end
                        end
                        else
                            tx_st_ff <= TX_IDLE;
                    end
                end
                default: tx_st_ff <= TX_IDLE;
            endcase
        end
    end
    assign TXD = txd_ff;

    // receiver, mid-bit sampling
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            rx_st_ff    <= TX_IDLE;
            rx_cnt_ff   <= '0;
            rx_bit_ff   <= '0;
            rx_sh_ff    <= '0;
            rx_data_ff  <= '0;
            rx_valid_ff <= 1'b0;
            rx_prev_ff  <= 1'b1;
        end
        else if (CE)
        begin
            rx_prev_ff  <= RXD;
            rx_valid_ff <= 1'b0;
            case (rx_st_ff)
                TX_IDLE:
                begin
                    if (rx_prev_ff && !RXD)
                    begin
                        rx_cnt_ff <= 16'(BIT_CYC / 2);
                        rx_st_ff  <= TX_START;
                    end
                end
                TX_START, TX_DATA, TX_STOP:
                begin
                    if (rx_cnt_ff != '0)
                        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
                    else
                    begin
                        rx_cnt_ff <= 16'(BIT_CYC - 1);
                        if (rx_st_ff == TX_START)
                        begin
                            rx_bit_ff <= '0;
                            rx_st_ff  <= RXD ? TX_IDLE : TX_DATA;
                        end
                        else if (rx_st_ff == TX_DATA)
                        begin
                            rx_sh_ff <= {RXD, rx_sh_ff[7:1]};
                            if (rx_bit_ff == 3'h7)
                                rx_st_ff <= TX_STOP;
                            rx_bit_ff <= rx_bit_ff + 3'h1;
                        end
                        else
                        begin
                            if (RXD)
                            begin
                                rx_data_ff  <= rx_sh_ff;
                                rx_valid_ff <= 1'b1;
                            end
                            rx_st_ff <= TX_IDLE;
                        end
                    end
                end
                default: rx_st_ff <= TX_IDLE;
            endcase
        end
    end
    assign RX_DATA  = rx_data_ff;
    assign RX_VALID = rx_valid_ff;

    // handshake: busy follows processing, rts low interrupts
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            busy_ff  <= 1'b0;
            intr_ff  <= 1'b0;
            rts_d_ff <= 1'b1;
        end
        else if (CE)
        begin
            rts_d_ff <= RTS_N;
            intr_ff  <= rx_valid_ff || (hs_en && !RTS_N && rts_d_ff);
            busy_ff  <= hs_en && PROCESSING && !intr_ff;
        end
    end
    assign BUSY      = busy_ff;
    assign INTERRUPT = intr_ff;
    assign BUF_LEVEL = 10'(level_ff);

    property p_idle_high;
        @(posedge CLK_SYS) disable iff (RST) (tx_st_ff == TX_IDLE && $past(tx_st_ff) == TX_IDLE) |-> TXD;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("txd low while idle");

    property p_busy_off_default;
        @(posedge CLK_SYS) disable iff (RST) !hs_en |-> ##1 !BUSY;
    endproperty
    a_busy_off_default: assert property (p_busy_off_default) else $error("busy with handshake off");

    property p_ovf_on_full;
        @(posedge CLK_SYS) disable iff (RST)
            (CE && src_ff == SRC_MSG && buf_full && MSG_VALID && msg_keep && !drop_char) |=> src_ff == SRC_OVF;
    endproperty
    a_ovf_on_full: assert property (p_ovf_on_full) else $error("no overflow report on full");

    property p_level_bound;
        @(posedge CLK_SYS) disable iff (RST) level_ff <= LW'(BUF_BYTES);
    endproperty
    a_level_bound: assert property (p_level_bound) else $error("buffer level exceeds size");

    property p_drop_char;
        @(posedge CLK_SYS) disable iff (RST) drop_char |-> !buf_push;
    endproperty
    a_drop_char: assert property (p_drop_char) else $error("suppressed char queued");

    property p_monitor_all;
        @(posedge CLK_SYS) disable iff (RST)
            (CE && src_ff == SRC_MSG && MSG_VALID && MONITOR_ALL && !FILTERS_SET && !drop_char && !buf_full)
            |=> level_ff == $past(level_ff) + LW'(1) - LW'($past(buf_pop));
    endproperty
    a_monitor_all: assert property (p_monitor_all) else $error("monitor-all byte not queued");

    property p_rts_interrupt;
        @(posedge CLK_SYS) disable iff (RST) (CE && hs_en && !RTS_N && rts_d_ff) |=> INTERRUPT ##1 !BUSY;
    endproperty
    a_rts_interrupt: assert property (p_rts_interrupt) else $error("rts did not interrupt");

    property p_busy_follows;
        @(posedge CLK_SYS) disable iff (RST) (CE && !PROCESSING) |=> !BUSY;
    endproperty
    a_busy_follows: assert property (p_busy_follows) else $error("busy while not processing");

    property p_start_bit;
        @(posedge CLK_SYS) disable iff (RST) (CE && tx_st_ff == TX_IDLE && from_fifo.valid) |=> !TXD;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("missing start bit");
endmodule : serial_host_port

/* verilog/stream_fifo.sv */
`timescale 1ns/1ps
module stream_fifo
    import host_port_pkg::*;
#(
    parameter int W = 8,
    parameter int D = 4
)(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    byte_stream_if.snk in_s,
    byte_stream_if.src out_s
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0]   cnt_ff;
    logic          push;
    logic          pop;

    assign in_s.ready  = (cnt_ff != (AW+1)'(D));
    assign out_s.valid = (cnt_ff != '0);
    assign out_s.data  = mem[rp_ff];
    assign push = ce && in_s.valid && in_s.ready;
    assign pop  = ce && out_s.valid && out_s.ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_ff] <= in_s.data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
                wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
            if (pop)
                rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : stream_fifo
